/* File: rtl/mem_router_defines.svh */
// Address map, master numbering and I/O window constants for the router
`ifndef MEM_ROUTER_DEFINES_SVH
`define MEM_ROUTER_DEFINES_SVH

// Byte address map (exclusive upper limits)
`define CORE_REG_LIMIT 24'h0000C0
`define DUAL_LIMIT 24'h010000
`define SINGLE_BASE 24'h010000
`define SINGLE_LIMIT 24'h050000
`define EXT_BASE 24'h050000
`define ROM_BASE 24'hFE0000
`define SINGLE_FIRST_IDX 6'h08
`define DUAL_PORTS 2

// Field positions of the byte address
`define DUAL_BLK_HI 15
`define DUAL_BLK_LO 13
`define SINGLE_BLK_HI 18
`define SINGLE_BLK_LO 13
`define ROM_BLK_HI 16
`define ROM_BLK_LO 15
`define ROM_WORD_HI 14
`define ROM_WORD_LO 1
`define REGION_HI 23
`define REGION_LO 22

// Master numbering
`define MST_CPU_PROG 0
`define MST_CPU_DATA 1
`define MST_DMA0 2
`define MST_DMA3 5
`define MST_LCD 6
`define MST_USB 7

// I/O word windows, inclusive bounds
`define IOW_IDLE_LO 16'h0000
`define IOW_IDLE_HI 16'h0004
`define IOW_DMA0_LO 16'h0C00
`define IOW_DMA0_HI 16'h0C7F
`define IOW_DMA1_LO 16'h0D00
`define IOW_DMA1_HI 16'h0D7F
`define IOW_DMA2_LO 16'h0E00
`define IOW_DMA2_HI 16'h0E7F
`define IOW_DMA3_LO 16'h0F00
`define IOW_DMA3_HI 16'h0F7F
`define IOW_EXTIF_LO 16'h1000
`define IOW_EXTIF_HI 16'h10DD
`define IOW_TMR0_LO 16'h1800
`define IOW_TMR0_HI 16'h181F
`define IOW_TMR1_LO 16'h1840
`define IOW_TMR1_HI 16'h185F
`define IOW_TMR2_LO 16'h1880
`define IOW_TMR2_HI 16'h189F
`define IOW_RTC_LO 16'h1900
`define IOW_RTC_HI 16'h197F
`define IOW_TWI_LO 16'h1A00
`define IOW_TWI_HI 16'h1A6C
`define IOW_UART_LO 16'h1B00
`define IOW_UART_HI 16'h1B1F
`define IOW_SYS_LO 16'h1C00
`define IOW_SYS_HI 16'h1CFF
`define IOW_AUD0_LO 16'h2800
`define IOW_AUD0_HI 16'h2840
`define IOW_AUD1_LO 16'h2900
`define IOW_AUD1_HI 16'h2940
`define IOW_AUD2_LO 16'h2A00
`define IOW_AUD2_HI 16'h2A40
`define IOW_AUD3_LO 16'h2B00
`define IOW_AUD3_HI 16'h2B40
`define IOW_LCD_LO 16'h2E00
`define IOW_LCD_HI 16'h2E40
`define IOW_SPI_LO 16'h3000
`define IOW_SPI_HI 16'h300F
`define IOW_CARD0_LO 16'h3A00
`define IOW_CARD0_HI 16'h3A1F
`define IOW_CARD1_LO 16'h3B00
`define IOW_CARD1_HI 16'h3B1F
`define IOW_ANALOG_LO 16'h7000
`define IOW_ANALOG_HI 16'h70FF
`define IOW_USB_LO 16'h8000
`define IOW_USB_HI 16'hFFFF

`endif

/* File: rtl/mem_router_pkg.sv */
// Types shared by the address decoder and the router
`include "mem_router_defines.svh"
package mem_router_pkg;

	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_CORE_REG = 3'b001,
		TGT_DUAL = 3'b010,
		TGT_SINGLE = 3'b011,
		TGT_ROM = 3'b100,
		TGT_EXT = 3'b101,
		TGT_IO = 3'b110,
		TGT_BLOCKED = 3'b111
	} target_e;

	typedef enum logic [4:0] {
		IOW_IDLE = 5'h00, IOW_DMA0 = 5'h01, IOW_DMA1 = 5'h02,
		IOW_DMA2 = 5'h03, IOW_DMA3 = 5'h04, IOW_EXTIF = 5'h05,
		IOW_TMR0 = 5'h06, IOW_TMR1 = 5'h07, IOW_TMR2 = 5'h08,
		IOW_RTC = 5'h09, IOW_TWI = 5'h0A, IOW_UART = 5'h0B,
		IOW_SYS = 5'h0C, IOW_AUD0 = 5'h0D, IOW_AUD1 = 5'h0E,
		IOW_AUD2 = 5'h0F, IOW_AUD3 = 5'h10, IOW_LCD = 5'h11,
		IOW_SPI = 5'h12, IOW_CARD0 = 5'h13, IOW_CARD1 = 5'h14,
		IOW_ANALOG = 5'h15, IOW_USB = 5'h16, IOW_RSVD = 5'h17
	} io_window_e;

	typedef logic [15:0] io_bound_t [23];

	// Table order follows the window codes above
	localparam io_bound_t IO_LO = '{
		`IOW_IDLE_LO, `IOW_DMA0_LO, `IOW_DMA1_LO, `IOW_DMA2_LO,
		`IOW_DMA3_LO, `IOW_EXTIF_LO, `IOW_TMR0_LO, `IOW_TMR1_LO,
		`IOW_TMR2_LO, `IOW_RTC_LO, `IOW_TWI_LO, `IOW_UART_LO,
		`IOW_SYS_LO, `IOW_AUD0_LO, `IOW_AUD1_LO, `IOW_AUD2_LO,
		`IOW_AUD3_LO, `IOW_LCD_LO, `IOW_SPI_LO, `IOW_CARD0_LO,
		`IOW_CARD1_LO, `IOW_ANALOG_LO, `IOW_USB_LO};
	localparam io_bound_t IO_HI = '{
		`IOW_IDLE_HI, `IOW_DMA0_HI, `IOW_DMA1_HI, `IOW_DMA2_HI,
		`IOW_DMA3_HI, `IOW_EXTIF_HI, `IOW_TMR0_HI, `IOW_TMR1_HI,
		`IOW_TMR2_HI, `IOW_RTC_HI, `IOW_TWI_HI, `IOW_UART_HI,
		`IOW_SYS_HI, `IOW_AUD0_HI, `IOW_AUD1_HI, `IOW_AUD2_HI,
		`IOW_AUD3_HI, `IOW_LCD_HI, `IOW_SPI_HI, `IOW_CARD0_HI,
		`IOW_CARD1_HI, `IOW_ANALOG_HI, `IOW_USB_HI};

endpackage

/* File: rtl/decode_if.sv */
// Decode result of one master, from its decoder to the router
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
	import mem_router_pkg::*;
	target_e target;
	logic [4:0] blk;
	logic [1:0] region;
	io_window_e win;
	modport dec (output target, output blk, output region, output win);
	modport rtr (input target, input blk, input region, input win);
endinterface
`default_nettype wire

/* File: rtl/addr_decoder.sv */
// Per-master address decoder with the master's access permissions
`timescale 1ns/1ps
`default_nettype none
`include "mem_router_defines.svh"
module addr_decoder import mem_router_pkg::*; #(
	parameter int MASTER_ID = 0
) (
	// Request
	input wire logic [23:0] addr_i,
	input wire logic io_i,
	input wire logic rom_remap_bit_i,
	// Result
	decode_if.dec res
);
	localparam bit IS_CPU = (MASTER_ID == `MST_CPU_PROG) ||
		(MASTER_ID == `MST_CPU_DATA);
	localparam bit IS_DMA = (MASTER_ID >= `MST_DMA0) &&
		(MASTER_ID <= `MST_DMA3);
	localparam bit EXT_OK = !IS_DMA || (MASTER_ID == `MST_DMA3);
	localparam bit DUAL_OK = (MASTER_ID != `MST_LCD) &&
		(MASTER_ID != `MST_USB);
	localparam bit ROM_OK = IS_CPU;
	localparam bit IO_OK = (MASTER_ID == `MST_CPU_DATA) || IS_DMA;

	wire logic in_core = addr_i < `CORE_REG_LIMIT;
	wire logic in_dual = addr_i < `DUAL_LIMIT;
	wire logic in_single = addr_i < `SINGLE_LIMIT;
	wire logic in_top = addr_i >= `ROM_BASE;
	wire logic rom_mapped = in_top && !rom_remap_bit_i;
	wire logic [5:0] single_idx =
		addr_i[`SINGLE_BLK_HI:`SINGLE_BLK_LO] - `SINGLE_FIRST_IDX;

	// Core registers, dual RAM, single RAM, then ROM; everything else is external
	target_e mem_tgt;
	assign mem_tgt =
		in_core ? (DUAL_OK ? TGT_CORE_REG : TGT_BLOCKED) :
		in_dual ? (DUAL_OK ? TGT_DUAL : TGT_BLOCKED) :
		in_single ? TGT_SINGLE :
		rom_mapped ? (ROM_OK ? TGT_ROM : TGT_BLOCKED) :
		(EXT_OK ? TGT_EXT : TGT_BLOCKED);

	assign res.target = io_i ? (IO_OK ? TGT_IO : TGT_BLOCKED) : mem_tgt;
	assign res.blk =
		in_dual ? {2'b00, addr_i[`DUAL_BLK_HI:`DUAL_BLK_LO]} :
		in_single ? single_idx[4:0] :
		{3'b000, addr_i[`ROM_BLK_HI:`ROM_BLK_LO]};
	assign res.region = addr_i[`REGION_HI:`REGION_LO];

	// First matching window wins; gaps fall to the reserved code
	always_comb begin
		res.win = IOW_RSVD;
		for (int i = 22; i >= 0; i--) begin
			if (addr_i[15:0] >= IO_LO[i] && addr_i[15:0] <= IO_HI[i]) begin
				res.win = io_window_e'(5'(i));
			end
		end
	end
endmodule // addr_decoder
`default_nettype wire

/* File: rtl/mem_router.sv */
// Memory map decoder and router for the on-chip bus masters
// Behaviour
// - ROM answers top region while remap bit clear
// - Remap bit set sends top region external
// - Hardware reset clears the remap bit
// - Software reset keeps the remap bit
// - Four ROM blocks, one word per cycle
// - Program and data buses may read ROM
// - From 050000h upward is external space
// - Four chip selects follow the region hit
// - External port: 16/8-bit data, 21-bit address
// - Separate I/O space, CPU I/O or DMA
// - I/O words decode to fixed peripheral windows
// - DMA controllers reach peripheral I/O windows
// - Dual-access block serves two accesses per cycle
// - Single-access block serves one access per cycle
// - Of the DMA masters, only DMA three reaches external space
// - Display and USB masters never reach dual RAM
// - Lowest 192 bytes go to core registers
// - Eight masters share one 16M-byte space
// - Dual RAM spans 000000h to 00FFFFh
// - Single RAM starts at 010000h, 32 blocks
`timescale 1ns/1ps
`default_nettype none
`include "mem_router_defines.svh"
module mem_router import mem_router_pkg::*; #(
	parameter int NUM_MASTERS = 8,
	parameter int DUAL_BLOCKS = 8,
	parameter int SINGLE_BLOCKS = 32,
	parameter int ROM_BLOCKS = 4,
	parameter int EXT_ADDR_W = 21
) (
	// Clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_rst_i,
	// Core status word three, remap field
	input wire logic remap_wr_i,
	input wire logic remap_wdata_i,
	output logic rom_remap_bit_o,
	// Bus masters
	input wire logic [NUM_MASTERS-1:0] mst_req_i,
	input wire logic [23:0] mst_addr_i [NUM_MASTERS],
	input wire logic [NUM_MASTERS-1:0] mst_we_i,
	input wire logic [NUM_MASTERS-1:0] mst_io_i,
	output logic [NUM_MASTERS-1:0] mst_ready_o,
	output logic [NUM_MASTERS-1:0] mst_err_o,
	output logic [NUM_MASTERS-1:0] mst_void_o,
	// Registered route of each granted master
	output logic [NUM_MASTERS-1:0] route_valid_o,
	output var target_e route_tgt_o [NUM_MASTERS],
	output logic [4:0] route_blk_o [NUM_MASTERS],
	output var io_window_e route_win_o [NUM_MASTERS],
	output logic [NUM_MASTERS-1:0] route_we_o,
	// On-chip memory strobes
	output logic core_sel_o,
	output logic [`DUAL_PORTS-1:0] dual_en_o [DUAL_BLOCKS],
	output logic [SINGLE_BLOCKS-1:0] single_en_o,
	output logic [ROM_BLOCKS-1:0] rom_en_o,
	output logic [13:0] rom_word_o [ROM_BLOCKS],
	// External memory port
	input wire logic ext_width8_i,
	output logic [3:0] external_region_select_o,
	output logic [EXT_ADDR_W-1:0] ext_addr_o,
	output logic ext_we_o,
	output logic [$clog2(NUM_MASTERS)-1:0] ext_owner_o
);
	localparam int MW = $clog2(NUM_MASTERS);

	// Remap field of the core status word
	logic rom_remap_bit_q;

	// Decode results copied out of the interface array
	target_e tgt [NUM_MASTERS];
	logic [4:0] blk [NUM_MASTERS];
	logic [1:0] region [NUM_MASTERS];
	io_window_e win [NUM_MASTERS];

	// Arbitration
	logic [NUM_MASTERS-1:0] void_io;
	logic [NUM_MASTERS-1:0] takes;
	logic [NUM_MASTERS-1:0] stall;
	logic [NUM_MASTERS-1:0] dport;
	logic [NUM_MASTERS-1:0] grant;

	// Strobe next values
	logic core_sel_d;
	logic [`DUAL_PORTS-1:0] dual_en_d [DUAL_BLOCKS];
	logic [SINGLE_BLOCKS-1:0] single_en_d;
	logic [ROM_BLOCKS-1:0] rom_en_d;
	logic [13:0] rom_word_d [ROM_BLOCKS];
	logic ext_hit;
	logic [MW-1:0] ext_idx;

	// Registers
	logic [NUM_MASTERS-1:0] route_valid_q;
	target_e route_tgt_q [NUM_MASTERS];
	logic [4:0] route_blk_q [NUM_MASTERS];
	io_window_e route_win_q [NUM_MASTERS];
	logic [NUM_MASTERS-1:0] route_we_q;
	logic core_sel_q;
	logic [`DUAL_PORTS-1:0] dual_en_q [DUAL_BLOCKS];
	logic [SINGLE_BLOCKS-1:0] single_en_q;
	logic [ROM_BLOCKS-1:0] rom_en_q;
	logic [13:0] rom_word_q [ROM_BLOCKS];
	logic [3:0] ext_cs_q;
	logic [EXT_ADDR_W-1:0] ext_addr_q;
	logic ext_we_q;
	logic [MW-1:0] ext_owner_q;

	// Only a hardware reset touches the remap field
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rom_remap_bit_q <= 1'b0;
		end else if (remap_wr_i) begin
			rom_remap_bit_q <= remap_wdata_i;
		end
	end

	// One decoder per master, permissions fixed by its position
	genvar g;
	generate
		for (g = 0; g < NUM_MASTERS; g++) begin : g_dec
			decode_if dif ();
			addr_decoder #(
				.MASTER_ID(g)
			) u_dec (
				.addr_i(mst_addr_i[g]),
				.io_i(mst_io_i[g]),
				.rom_remap_bit_i(rom_remap_bit_q),
				.res(dif.dec)
			);
			assign tgt[g] = dif.target;
			assign blk[g] = dif.blk;
			assign region[g] = dif.region;
			assign win[g] = dif.win;
			assign void_io[g] = mst_req_i[g] && (dif.target == TGT_IO) &&
				(dif.win == IOW_RSVD);
			assign takes[g] = mst_req_i[g] && !void_io[g] &&
				(dif.target != TGT_NONE) && (dif.target != TGT_BLOCKED);
		end
	endgenerate

	// Fixed priority, lowest master number first. A low number that
	// keeps requesting can starve a higher one; masters must space out.
	always_comb begin
		int seen;
		logic clash;
		seen = 0;
		clash = 1'b0;
		for (int m = 0; m < NUM_MASTERS; m++) begin
			seen = 0;
			clash = 1'b0;
			for (int k = 0; k < m; k++) begin
				if (takes[k] && tgt[k] == tgt[m]) begin
					if (tgt[m] == TGT_DUAL && blk[k] == blk[m]) begin
						seen++;
					end else if (tgt[m] == TGT_EXT || tgt[m] == TGT_IO ||
						blk[k] == blk[m]) begin
						clash = 1'b1;
					end
				end
			end
			stall[m] = takes[m] && (clash || seen >= `DUAL_PORTS);
			dport[m] = seen > 0;
		end
	end

	// Blocked accesses finish at once with an error, nothing selected
	assign grant = takes & ~stall;
	assign mst_ready_o = grant | void_io;
	assign mst_void_o = void_io;
	always_comb begin
		for (int m = 0; m < NUM_MASTERS; m++) begin
			mst_err_o[m] = mst_req_i[m] && (tgt[m] == TGT_BLOCKED);
		end
	end

	// Strobes towards the memories for the granted masters
	always_comb begin
		core_sel_d = 1'b0;
		single_en_d = '0;
		rom_en_d = '0;
		ext_hit = 1'b0;
		ext_idx = '0;
		for (int b = 0; b < DUAL_BLOCKS; b++) begin
			dual_en_d[b] = '0;
		end
		for (int r = 0; r < ROM_BLOCKS; r++) begin
			rom_word_d[r] = rom_word_q[r];
		end
		for (int m = 0; m < NUM_MASTERS; m++) begin
			if (grant[m]) begin
				if (tgt[m] == TGT_CORE_REG) begin
					core_sel_d = 1'b1;
				end else if (tgt[m] == TGT_DUAL) begin
					dual_en_d[blk[m][2:0]][dport[m]] = 1'b1;
				end else if (tgt[m] == TGT_SINGLE) begin
					single_en_d[blk[m]] = 1'b1;
				end else if (tgt[m] == TGT_ROM) begin
					rom_en_d[blk[m][1:0]] = 1'b1;
					rom_word_d[blk[m][1:0]] =
						mst_addr_i[m][`ROM_WORD_HI:`ROM_WORD_LO];
				end else if (tgt[m] == TGT_EXT) begin
					ext_hit = 1'b1;
					ext_idx = MW'(m);
				end
			end
		end
	end

	// External side: 8-bit mode moves bytes, 16-bit mode moves words
	wire logic [23:0] ext_byte = mst_addr_i[ext_idx];
	wire logic [EXT_ADDR_W-1:0] ext_addr_d = ext_width8_i ?
		ext_byte[EXT_ADDR_W-1:0] : ext_byte[EXT_ADDR_W:1];
	wire logic [3:0] ext_cs_d = ext_hit ?
		(4'h1 << region[ext_idx]) : 4'h0;

	// Soft reset drops pending routes but leaves the remap field alone
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || soft_rst_i) begin
			route_valid_q <= '0;
			route_we_q <= '0;
			core_sel_q <= 1'b0;
			single_en_q <= '0;
			rom_en_q <= '0;
			ext_cs_q <= 4'h0;
			ext_we_q <= 1'b0;
		end else begin
			route_valid_q <= grant;
			route_we_q <= mst_we_i & grant;
			core_sel_q <= core_sel_d;
			single_en_q <= single_en_d;
			rom_en_q <= rom_en_d;
			ext_cs_q <= ext_cs_d;
			ext_we_q <= ext_hit && mst_we_i[ext_idx];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || soft_rst_i) begin
			ext_addr_q <= '0;
			ext_owner_q <= '0;
		end else if (ext_hit) begin
			ext_addr_q <= ext_addr_d;
			ext_owner_q <= ext_idx;
		end
	end

	// Routes and dual ports kept per entry so the arrays stay uniform
	generate
		for (g = 0; g < NUM_MASTERS; g++) begin : g_route
			always_ff @(posedge clk_i) begin
				if (sys_rst_i || soft_rst_i) begin
					route_tgt_q[g] <= TGT_NONE;
					route_blk_q[g] <= 5'h00;
					route_win_q[g] <= IOW_RSVD;
				end else begin
					route_tgt_q[g] <= grant[g] ? tgt[g] : TGT_NONE;
					route_blk_q[g] <= grant[g] ? blk[g] : 5'h00;
					route_win_q[g] <= grant[g] ? win[g] : IOW_RSVD;
				end
			end
		end
		for (g = 0; g < DUAL_BLOCKS; g++) begin : g_dual
			always_ff @(posedge clk_i) begin
				if (sys_rst_i || soft_rst_i) begin
					dual_en_q[g] <= '0;
				end else begin
					dual_en_q[g] <= dual_en_d[g];
				end
			end
		end
		for (g = 0; g < ROM_BLOCKS; g++) begin : g_rom
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					rom_word_q[g] <= 14'h0000;
				end else begin
					rom_word_q[g] <= rom_word_d[g];
				end
			end
		end
	endgenerate

	assign rom_remap_bit_o = rom_remap_bit_q;
	assign route_valid_o = route_valid_q;
	assign route_tgt_o = route_tgt_q;
	assign route_blk_o = route_blk_q;
	assign route_win_o = route_win_q;
	assign route_we_o = route_we_q;
	assign core_sel_o = core_sel_q;
	assign dual_en_o = dual_en_q;
	assign single_en_o = single_en_q;
	assign rom_en_o = rom_en_q;
	assign rom_word_o = rom_word_q;
	assign external_region_select_o = ext_cs_q;
	assign ext_addr_o = ext_addr_q;
	assign ext_we_o = ext_we_q;
	assign ext_owner_o = ext_owner_q;

endmodule // mem_router
`default_nettype wire

/* File: verif/mem_router_assertions.sv */
// Concurrent checks on the router's ports
`timescale 1ns/1ps
`default_nettype none
module mem_router_assertions import mem_router_pkg::*; #(
	parameter int NUM_MASTERS = 8
) (
	// Clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_rst_i,
	// Remap field
	input wire logic remap_wr_i,
	input wire logic rom_remap_bit_o,
	// Masters
	input wire logic [NUM_MASTERS-1:0] mst_req_i,
	input wire logic [23:0] mst_addr_i [NUM_MASTERS],
	input wire logic [NUM_MASTERS-1:0] mst_io_i,
	input wire logic [NUM_MASTERS-1:0] mst_ready_o,
	input wire logic [NUM_MASTERS-1:0] mst_err_o,
	input wire logic [NUM_MASTERS-1:0] mst_void_o,
	// Routes
	input wire logic [NUM_MASTERS-1:0] route_valid_o,
	input var target_e route_tgt_o [NUM_MASTERS],
	input wire logic core_sel_o,
	input wire logic [3:0] external_region_select_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Master 0 wins every conflict, so its grant is unconditional
	wire top0 = mst_req_i[0] && !mst_io_i[0] && !soft_rst_i &&
		mst_addr_i[0][23:17] == 7'h7F;
	property p_rom_map;
		top0 && !rom_remap_bit_o |-> mst_ready_o[0] ##1
			route_tgt_o[0] == TGT_ROM;
	endproperty
	a_rom_map: assert property (p_rom_map)
		else $error("top region not routed to ROM");
	property p_remap;
		top0 && rom_remap_bit_o |-> mst_ready_o[0] ##1
			route_tgt_o[0] == TGT_EXT && external_region_select_o == 4'h8;
	endproperty
	a_remap: assert property (p_remap)
		else $error("remapped top region not external");
	property p_hw_rst;
		disable iff (1'h0) sys_rst_i |=> !rom_remap_bit_o;
	endproperty
	a_hw_rst: assert property (p_hw_rst)
		else $error("remap bit survived hardware reset");
	property p_soft;
		soft_rst_i && !remap_wr_i |=> $stable(rom_remap_bit_o);
	endproperty
	a_soft: assert property (p_soft)
		else $error("software reset changed the remap bit");
	property p_dma_ext;
		mst_req_i[2] && !mst_io_i[2] && mst_addr_i[2] >= 24'h050000
			|-> mst_err_o[2] && !mst_ready_o[2];
	endproperty
	a_dma_ext: assert property (p_dma_ext)
		else $error("first DMA reached external space");
	property p_usb_dual;
		mst_req_i[7] && !mst_io_i[7] && mst_addr_i[7] < 24'h010000
			|-> mst_err_o[7] && !mst_ready_o[7];
	endproperty
	a_usb_dual: assert property (p_usb_dual)
		else $error("USB master reached dual RAM");
	property p_core;
		mst_req_i[1] && !mst_req_i[0] && !mst_io_i[1] && !soft_rst_i &&
			mst_addr_i[1] < 24'h0000C0 |-> ##1 core_sel_o && route_valid_o[1];
	endproperty
	a_core: assert property (p_core)
		else $error("low bytes missed the core registers");
	property p_void;
		mst_req_i[1] && mst_io_i[1] && mst_addr_i[1][15:0] == 16'h0005
			|-> mst_void_o[1] && mst_ready_o[1] ##1 !route_valid_o[1];
	endproperty
	a_void: assert property (p_void)
		else $error("reserved I/O word not voided");
	c_conflict: cover property (mst_req_i[2] && mst_req_i[1] && !mst_ready_o[2]);
	c_remap: cover property ($rose(rom_remap_bit_o));
	c_void: cover property (mst_void_o[1]);
endmodule // mem_router_assertions
bind mem_router mem_router_assertions #(
	.NUM_MASTERS(NUM_MASTERS)
) mem_router_assertions_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
	.remap_wr_i(remap_wr_i), .rom_remap_bit_o(rom_remap_bit_o),
	.mst_req_i(mst_req_i), .mst_addr_i(mst_addr_i), .mst_io_i(mst_io_i),
	.mst_ready_o(mst_ready_o), .mst_err_o(mst_err_o),
	.mst_void_o(mst_void_o), .route_valid_o(route_valid_o),
	.route_tgt_o(route_tgt_o), .core_sel_o(core_sel_o),
	.external_region_select_o(external_region_select_o)
);
`default_nettype wire

/* File: verif/bus_master_model.sv */
// Behavioural bus master that holds a request until it is answered
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	// Control from the bench
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [23:0] a_i,
	input wire logic io_i,
	input wire logic we_i,
	// Router side
	input wire logic ready_i,
	input wire logic err_i,
	input wire logic void_i,
	output logic req_o,
	output logic [23:0] addr_o,
	output logic io_o,
	output logic we_o,
	// Outcome
	output logic done_o,
	output logic err_o,
	output logic void_o,
	output logic [3:0] waits_o
);
	initial begin
		{req_o, addr_o, io_o, we_o} = '0;
		{done_o, err_o, void_o, waits_o} = '0;
	end
	// Released address turns to its inverse, never a stale copy
	always @(posedge clk_i) begin
		if (rst_i) begin
			{req_o, done_o} <= 2'h0;
		end else if (go_i) begin
			{req_o, addr_o, io_o, we_o} <= {1'h1, a_i, io_i, we_i};
			{done_o, waits_o} <= '0;
		end else if (req_o && (ready_i || err_i)) begin
			{req_o, done_o, err_o, void_o} <= {2'h1, err_i, void_i};
			addr_o <= ~addr_o;
		end else if (req_o) begin
			waits_o <= waits_o + 4'h1;
		end
	end
endmodule // bus_master_model
`default_nettype wire

/* File: verif/mem_router_tb.sv */
// Self-checking bench for the memory map router
`timescale 1ns/1ps
`default_nettype none
module mem_router_tb import mem_router_pkg::*;;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic soft_rst_i = 1'h0;
	logic remap_wr_i = 1'h0;
	logic remap_wdata_i = 1'h0;
	logic ext_width8_i = 1'h0;
	logic [7:0] go = '0, io_b = '0, we_b = '0;
	logic [23:0] a [8] = '{default: '0};
	wire [7:0] req, we, io, rdy, err, vd, done, e_q, v_q;
	wire [23:0] addr [8];
	wire [3:0] waits [8];
	logic rmp, core_sel, ext_we;
	logic [7:0] r_valid, r_we;
	target_e r_tgt [8];
	logic [4:0] r_blk [8];
	io_window_e r_win [8];
	logic [1:0] dual_en [8];
	logic [31:0] single_en;
	logic [3:0] rom_en, ext_sel;
	logic [13:0] rom_word [4];
	logic [20:0] ext_addr;
	logic [2:0] ext_owner;
	int fails = 0, n_checks = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	mem_router mem_router_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
		.remap_wr_i(remap_wr_i), .remap_wdata_i(remap_wdata_i),
		.rom_remap_bit_o(rmp), .mst_req_i(req), .mst_addr_i(addr),
		.mst_we_i(we), .mst_io_i(io), .mst_ready_o(rdy), .mst_err_o(err),
		.mst_void_o(vd), .route_valid_o(r_valid), .route_tgt_o(r_tgt),
		.route_blk_o(r_blk), .route_win_o(r_win), .route_we_o(r_we),
		.core_sel_o(core_sel), .dual_en_o(dual_en),
		.single_en_o(single_en), .rom_en_o(rom_en), .rom_word_o(rom_word),
		.ext_width8_i(ext_width8_i), .external_region_select_o(ext_sel),
		.ext_addr_o(ext_addr), .ext_we_o(ext_we), .ext_owner_o(ext_owner)
	);
	for (genvar g = 0; g < 8; g++) begin : g_mst
		bus_master_model bus_master_model_i (
			.clk_i(clk_i), .rst_i(sys_rst_i), .go_i(go[g]), .a_i(a[g]),
			.io_i(io_b[g]), .we_i(we_b[g]), .ready_i(rdy[g]),
			.err_i(err[g]), .void_i(vd[g]), .req_o(req[g]),
			.addr_o(addr[g]), .io_o(io[g]), .we_o(we[g]), .done_o(done[g]),
			.err_o(e_q[g]), .void_o(v_q[g]), .waits_o(waits[g])
		);
	end
	task automatic test_done();
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic start(input int m, input logic [23:0] ad,
		input logic i_v, input logic w_v);
		go[m] <= 1'h1;
		a[m] <= ad;
		io_b[m] <= i_v;
		we_b[m] <= w_v;
	endtask
	// Returns while the route of this master is on show
	task automatic wt(input int m);
		int k;
		@(posedge clk_i);
		go <= '0;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (done[m] === 1'h1) break;
		end
		if (k == 20) chk(0, 1);
	endtask
	task automatic acc(input int m, input logic [23:0] ad,
		input logic i_v, input logic w_v);
		start(m, ad, i_v, w_v);
		wt(m);
	endtask
	task automatic t_rom();
		logic [23:0] ad;
		for (int b = 0; b < 4; b++) begin
			ad = {7'h7F, b[1:0], 15'h0006};
			acc(b % 2, ad, 1'h0, 1'h0);
			chk(r_tgt[b % 2], TGT_ROM);
			chk(r_blk[b % 2], b);
			chk({rom_en[b], rom_word[b]}, 15'h4003);
		end
		acc(3, 24'hFF0000, 1'h0, 1'h0);
		chk({e_q[3], r_valid[3]}, 2'h2);
	endtask
	task automatic t_ext();
		logic [23:0] ad;
		for (int r = 0; r < 4; r++) begin
			ad = (r == 0) ? 24'h050010 : {r[1:0], 22'h000010};
			ext_width8_i <= r[0];
			acc(5, ad, 1'h0, r[0]);
			chk(ext_sel, 4'h1 << r);
			chk(ext_addr, r[0] ? ad[20:0] : ad[21:1]);
			chk({ext_owner, ext_we}, {3'h5, r[0]});
		end
		for (int m = 2; m < 5; m++) begin
			acc(m, 24'h400000, 1'h0, 1'h0);
			chk(e_q[m], 1);
		end
	endtask
	task automatic t_remap();
		remap_wr_i <= 1'h1;
		remap_wdata_i <= 1'h1;
		@(posedge clk_i);
		remap_wr_i <= 1'h0;
		acc(0, 24'hFE0000, 1'h0, 1'h0);
		chk(r_tgt[0], TGT_EXT);
		chk(ext_sel, 4'h8);
		soft_rst_i <= 1'h1;
		@(posedge clk_i);
		soft_rst_i <= 1'h0;
		@(posedge clk_i);
		chk({rmp, r_valid}, 9'h100);
		sys_rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		chk(rmp, 0);
		acc(1, 24'hFE0000, 1'h0, 1'h0);
		chk(r_tgt[1], TGT_ROM);
	endtask
	task automatic t_ram();
		acc(1, 24'h000040, 1'h0, 1'h0);
		chk({core_sel, r_tgt[1]}, {1'h1, TGT_CORE_REG});
		acc(1, 24'h0020C0, 1'h0, 1'h1);
		chk({r_tgt[1], r_blk[1], r_we[1]}, {TGT_DUAL, 5'h01, 1'h1});
		chk(dual_en[1], 2'h1);
		acc(7, 24'h004000, 1'h0, 1'h0);
		chk(e_q[7], 1);
		acc(6, 24'h00E000, 1'h0, 1'h0);
		chk(e_q[6], 1);
		acc(7, 24'h04E000, 1'h0, 1'h0);
		chk({r_tgt[7], r_blk[7]}, {TGT_SINGLE, 5'h1F});
		start(0, 24'h006000, 1'h0, 1'h0);
		start(1, 24'h007000, 1'h0, 1'h0);
		wt(0);
		chk(dual_en[3], 2'h3);
		wt(1);
		chk({waits[0], waits[1]}, 0);
		start(1, 24'h012000, 1'h0, 1'h0);
		start(2, 24'h013FFE, 1'h0, 1'h0);
		wt(1);
		chk(single_en, 32'h2);
		wt(2);
		chk({waits[1], waits[2]}, 8'h01);
	endtask
	task automatic t_io();
		logic [15:0] ioa [5] = '{16'h0004, 16'h0C7F, 16'h1000, 16'h1A6C,
			16'h8000};
		io_window_e iow [5] = '{IOW_IDLE, IOW_DMA0, IOW_EXTIF, IOW_TWI,
			IOW_USB};
		for (int i = 0; i < 5; i++) begin
			acc(1 + i % 2 * 2, {8'h00, ioa[i]}, 1'h1, 1'h0);
			chk(r_tgt[1 + i % 2 * 2], TGT_IO);
			chk(r_win[1 + i % 2 * 2], iow[i]);
		end
		acc(1, 24'h000005, 1'h1, 1'h0);
		chk({v_q[1], e_q[1], r_valid[1]}, 3'h4);
		acc(2, 24'h000C80, 1'h1, 1'h1);
		chk({v_q[2], r_valid[2]}, 2'h2);
		acc(0, 24'h001000, 1'h1, 1'h0);
		chk(e_q[0], 1);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		chk({rmp, r_valid}, 0);
		t_rom();
		t_ext();
		t_remap();
		t_ram();
		t_io();
		test_done();
	end
endmodule // mem_router_tb
`default_nettype wire
